/* design/pa_pkg.sv */
// Package: register map, field positions, reset values and counts of the pulse accumulator block
package pa_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_HZ        = 50_000_000;
   localparam int GATE_DIV      = 64;            // Gated clock is the module clock divided by 64
   localparam int GATE_DIV_W    = $clog2(GATE_DIV);
   localparam logic [GATE_DIV_W-1:0] GATE_DIV_LAST = GATE_DIV_W'(GATE_DIV - 1);

   // ------------------------------------------------------------
   // Register word index (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [2:0] IDX_FLAG    = 3'h0;
   localparam logic [2:0] IDX_COUNT   = 3'h1;
   localparam logic [2:0] IDX_PDATA   = 3'h2;
   localparam logic [2:0] IDX_PDIR    = 3'h3;
   localparam logic [2:0] IDX_CTRL    = 3'h4;
   localparam int         MAP_TOP_BIT = 5;       // Addresses at or above bit 5 are unmapped

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int FLG_INPUT   = 0;
   localparam int FLG_OVF     = 1;
   localparam int CTL_IN_IE   = 0;
   localparam int CTL_OVF_IE  = 1;
   localparam int CTL_EDGE    = 4;
   localparam int CTL_MODE    = 5;
   localparam int CTL_ENABLE  = 6;
   localparam int CTL_FAST    = 7;
   localparam int CTL_TIMER   = 8;

   // ------------------------------------------------------------
   // Widths and reset values
   // ------------------------------------------------------------
   localparam int          PORT_W      = 4;
   localparam int          ACC_W       = 16;
   localparam int          ACC_PIN     = 3;       // Accumulator input shares port pin 3
   localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
   localparam logic [15:0] COUNT_RST   = 16'h0000;
   localparam logic [3:0]  PDATA_RST   = 4'h0;
   localparam logic [3:0]  PDIR_RST    = 4'h0;
   localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

endpackage : pa_pkg

/* design/pa_sync.sv */
// Two-stage synchroniser for a group of pin levels
module pa_sync
   import pa_pkg::*;
#(
   parameter int W = 4
) (
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // Asynchronous levels and their synchronised copy
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } pa_sync_s;

   pa_sync_s s_r;
   pa_sync_s s_nxt;

   // Stage one feeds only stage two, never any logic
   always_comb begin
      s_nxt        = s_r;
      s_nxt.stage1 = async_in;
      s_nxt.stage2 = s_r.stage1;
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sync_out = s_r.stage2;

endmodule // pa_sync

/* design/pa_div.sv */
// Divider making a one-cycle enable pulse every GATE_DIV clocks while running
module pa_div
   import pa_pkg::*;
(
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Run control and divided pulse
   input  wire logic run,
   output logic      tick
);

   typedef struct packed {
      logic [GATE_DIV_W-1:0] cnt;
      logic                  tick;
   } pa_div_s;

   pa_div_s s_r;
   pa_div_s s_nxt;

   // Count only while running; a stopped timer gives no divided clock
   always_comb begin
      s_nxt      = s_r;
      s_nxt.tick = 1'b0;
      if (!run) begin
         s_nxt.cnt = '0;
      end else if (s_r.cnt == GATE_DIV_LAST) begin
         s_nxt.cnt  = '0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt + GATE_DIV_W'(1);
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick = s_r.tick;

endmodule // pa_div

/* design/pa_top.sv */
// Pulse accumulator flags, count and timer port registers behind an AHB-Lite slave
//
// Notes on behaviour
// - Overflow flag sets on wrap FFFF to 0000.
// - Overflow interrupt when flag and enable set.
// - Overflow flag: write one clears, zero keeps.
// - Event mode: selected input edge sets input flag.
// - Gated mode: gate trailing edge sets input flag.
// - Input interrupt when flag and enable set.
// - Input flag: write one clears, zero keeps.
// - Fast clear: count access clears both flags.
// - Count register counts events, read/write anytime.
// - Accumulator input synchronised before counting.
// - Port data buffered, drives non-compare pins.
// - Port read: pin if input, latch if output.
// - Writes never change compare-owned pin level.
// - Direction one output; reset makes inputs.
// - Edge select picks rising or falling count.
// - Gated mode counts divide-by-64 ticks while gated.
//
// Implementation choices: the AHB-Lite register port and the address map.
module pa_top
   import pa_pkg::*;
(
   // Clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic      [31:0]       hrdata,
   // Output compare ownership of the port pins
   input  wire logic [PORT_W-1:0] oc_pin_use,
   input  wire logic [PORT_W-1:0] oc_pin_level,
   // Timer port pins
   input  wire logic [PORT_W-1:0] port_pin_in,
   output logic      [PORT_W-1:0] port_pin_out,
   output logic      [PORT_W-1:0] port_pin_oe,
   // Interrupt requests
   output logic                   overflow_irq,
   output logic                   input_irq
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic              hreadyout;
      logic [31:0]       hrdata;
      logic              ph_wr;
      logic [2:0]        ph_idx;
      logic              accum_overflow_flag;
      logic              accum_input_flag;
      logic [ACC_W-1:0]  accum_count;
      logic [PORT_W-1:0] port_pin_data;
      logic [PORT_W-1:0] pin_direction;
      logic              input_irq_enable;
      logic              overflow_irq_enable;
      logic              accum_edge_select;
      logic              accum_mode_select;
      logic              accum_enable;
      logic              fast_flag_clear_all;
      logic              timer_enable;
      logic              pai_prev;
      logic              ovf_irq;
      logic              in_irq;
      logic [PORT_W-1:0] pin_out;
      logic [PORT_W-1:0] pin_oe;
   } pa_state_s;

   pa_state_s s_r;
   pa_state_s s_nxt;

   logic [PORT_W-1:0] pin_sync;
   logic              gate_tick;
   logic              accum_input;
   logic              acc_req;
   logic              acc_mapped;
   logic [2:0]        acc_idx;
   logic              cnt_inc;
   logic              in_event;
   logic              cnt_wr;
   logic              rise;
   logic              fall;

   // ------------------------------------------------------------
   // Pin synchroniser and divided clock
   // ------------------------------------------------------------
   // All port pins pass two flops; the accumulator input is one of them
   pa_sync #(
      .W        (PORT_W)
   ) u_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (port_pin_in),
      .sync_out (pin_sync)
   );

   // The divided clock stands still while the timer is off
   pa_div u_div (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .run      (s_r.timer_enable),
      .tick     (gate_tick)
   );

   assign accum_input = pin_sync[ACC_PIN];

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      s_nxt      = s_r;
      cnt_inc    = 1'b0;
      in_event   = 1'b0;
      acc_req    = hsel & htrans[1] & hready;
      acc_mapped = (haddr[31:MAP_TOP_BIT] == '0);
      acc_idx    = haddr[4:2];
      cnt_wr     = s_r.ph_wr & (s_r.ph_idx == IDX_COUNT);
      rise       = accum_input & ~s_r.pai_prev;
      fall       = ~accum_input & s_r.pai_prev;
      s_nxt.pai_prev = accum_input;

      // Data phase of a write; upper bits are dropped
      if (s_r.ph_wr) begin
         case (s_r.ph_idx)
            IDX_PDATA: s_nxt.port_pin_data = hwdata[PORT_W-1:0];
            IDX_PDIR:  s_nxt.pin_direction = hwdata[PORT_W-1:0];
            IDX_CTRL: begin
               s_nxt.input_irq_enable    = hwdata[CTL_IN_IE];
               s_nxt.overflow_irq_enable = hwdata[CTL_OVF_IE];
               s_nxt.accum_edge_select   = hwdata[CTL_EDGE];
               s_nxt.accum_mode_select   = hwdata[CTL_MODE];
               s_nxt.accum_enable        = hwdata[CTL_ENABLE];
               s_nxt.fast_flag_clear_all = hwdata[CTL_FAST];
               s_nxt.timer_enable        = hwdata[CTL_TIMER];
            end
            default: begin
            end
         endcase
      end

      // Qualified events: edge counting or gated divided clock
      if (s_r.accum_enable) begin
         if (!s_r.accum_mode_select) begin
            in_event = s_r.accum_edge_select ? rise : fall;
            cnt_inc  = in_event;
         end else begin
            // Edge select one gates on low level, trailing edge is rising
            in_event = s_r.accum_edge_select ? rise : fall;
            cnt_inc  = gate_tick & (s_r.accum_edge_select ? ~accum_input
                                                          : accum_input);
         end
      end

      // A software load beats a count in the same cycle
      if (cnt_wr) begin
         s_nxt.accum_count = hwdata[ACC_W-1:0];
      end else if (cnt_inc) begin
         s_nxt.accum_count = s_r.accum_count + 16'h0001;
      end

      // Flag clears first, so a set in the same cycle wins
      if (s_r.fast_flag_clear_all && acc_req && acc_mapped && acc_idx == IDX_COUNT) begin
         s_nxt.accum_overflow_flag = 1'b0;
         s_nxt.accum_input_flag    = 1'b0;
      end
      if (s_r.ph_wr && s_r.ph_idx == IDX_FLAG) begin
         if (hwdata[FLG_OVF]) begin
            s_nxt.accum_overflow_flag = 1'b0;
         end
         if (hwdata[FLG_INPUT]) begin
            s_nxt.accum_input_flag = 1'b0;
         end
      end
      if (cnt_inc && !cnt_wr && s_r.accum_count == COUNT_MAX) begin
         s_nxt.accum_overflow_flag = 1'b1;
      end
      if (in_event) begin
         s_nxt.accum_input_flag = 1'b1;
      end

      // Interrupt requests follow the flags and their enables
      s_nxt.ovf_irq = s_nxt.accum_overflow_flag & s_nxt.overflow_irq_enable;
      s_nxt.in_irq  = s_nxt.accum_input_flag & s_nxt.input_irq_enable;

      // Pins: output compare owns a pin ahead of the buffered data
      for (int i = 0; i < PORT_W; i++) begin
         s_nxt.pin_out[i] = oc_pin_use[i] ? oc_pin_level[i]
                                          : s_nxt.port_pin_data[i];
         s_nxt.pin_oe[i]  = oc_pin_use[i] | s_nxt.pin_direction[i];
      end

      // Bus address phase; read data is taken from the updated state, except the count and input-pin levels, which come from the current register and synchroniser
      s_nxt.hreadyout = 1'b1;
      s_nxt.ph_wr     = acc_req & hwrite & acc_mapped;
      s_nxt.ph_idx    = acc_idx;
      if (acc_req && !hwrite) begin
         s_nxt.hrdata = 32'h0000_0000;
         if (acc_mapped) begin
            case (acc_idx)
               IDX_FLAG: begin
                  s_nxt.hrdata[FLG_OVF]   = s_nxt.accum_overflow_flag;
                  s_nxt.hrdata[FLG_INPUT] = s_nxt.accum_input_flag;
               end
               IDX_COUNT: s_nxt.hrdata[ACC_W-1:0] = s_r.accum_count;
               IDX_PDATA: begin
                  for (int i = 0; i < PORT_W; i++) begin
                     s_nxt.hrdata[i] = s_nxt.pin_direction[i] ? s_nxt.port_pin_data[i]
                                                              : pin_sync[i];
                  end
               end
               IDX_PDIR: s_nxt.hrdata[PORT_W-1:0] = s_nxt.pin_direction;
               IDX_CTRL: begin
                  s_nxt.hrdata[CTL_IN_IE]  = s_nxt.input_irq_enable;
                  s_nxt.hrdata[CTL_OVF_IE] = s_nxt.overflow_irq_enable;
                  s_nxt.hrdata[CTL_EDGE]   = s_nxt.accum_edge_select;
                  s_nxt.hrdata[CTL_MODE]   = s_nxt.accum_mode_select;
                  s_nxt.hrdata[CTL_ENABLE] = s_nxt.accum_enable;
                  s_nxt.hrdata[CTL_FAST]   = s_nxt.fast_flag_clear_all;
                  s_nxt.hrdata[CTL_TIMER]  = s_nxt.timer_enable;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r               <= '0;
         s_r.hreadyout     <= 1'b1;
         s_r.hrdata        <= RDATA_RST;
         s_r.accum_count   <= COUNT_RST;
         s_r.port_pin_data <= PDATA_RST;
         s_r.pin_direction <= PDIR_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register; hresp is tied low
   assign hreadyout    = s_r.hreadyout;
   assign hresp        = 1'b0;
   assign hrdata       = s_r.hrdata;
   assign port_pin_out = s_r.pin_out;
   assign port_pin_oe  = s_r.pin_oe;
   assign overflow_irq = s_r.ovf_irq;
   assign input_irq    = s_r.in_irq;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_ovf_wrap_set: assert property (
      cnt_inc && !cnt_wr && s_r.accum_count == COUNT_MAX
      |=> s_r.accum_overflow_flag && s_r.accum_count == COUNT_RST)
      else $error("overflow flag not set on wrap");

   a_ovf_irq_tie: assert property (
      s_r.accum_overflow_flag && s_r.overflow_irq_enable |-> overflow_irq)
      else $error("overflow interrupt missing");

   a_w1c_ovf_clear: assert property (
      s_r.ph_wr && s_r.ph_idx == IDX_FLAG && hwdata[FLG_OVF] && !cnt_inc
      |=> !s_r.accum_overflow_flag && !overflow_irq)
      else $error("overflow flag not cleared by one");

   a_w0_ovf_keep: assert property (
      s_r.ph_wr && s_r.ph_idx == IDX_FLAG && !hwdata[FLG_OVF] && s_r.accum_overflow_flag
      && !(s_r.fast_flag_clear_all && acc_req)
      |=> s_r.accum_overflow_flag)
      else $error("overflow flag lost on zero write");

   a_edge_flag_set: assert property (
      s_r.accum_enable && !s_r.accum_mode_select && s_r.accum_edge_select && rise
      |=> s_r.accum_input_flag)
      else $error("input flag not set on rising edge");

   a_in_irq_tie: assert property (
      $rose(s_r.accum_input_flag) && s_r.input_irq_enable |-> input_irq)
      else $error("input interrupt missing");

   a_fast_clear: assert property (
      s_r.fast_flag_clear_all && acc_req && acc_mapped && acc_idx == IDX_COUNT
      && !in_event && !cnt_inc
      |=> !s_r.accum_overflow_flag && !s_r.accum_input_flag)
      else $error("fast clear failed");

   a_count_step: assert property (
      cnt_inc && !cnt_wr |=> s_r.accum_count == $past(s_r.accum_count) + 16'h0001)
      else $error("count did not step by one");

   a_oc_pin_hold: assert property (
      oc_pin_use[0] && $stable(oc_pin_use) && $stable(oc_pin_level)
      |=> port_pin_out[0] == $past(oc_pin_level[0]) && port_pin_oe[0])
      else $error("compare-owned pin changed");

   a_ready_zero_wait: assert property (
      hreadyout && !hresp)
      else $error("slave inserted wait or error");

   a_fall_flag_set: assert property (
      s_r.accum_enable && !s_r.accum_mode_select && !s_r.accum_edge_select && fall
      |=> s_r.accum_input_flag)
      else $error("input flag not set on falling edge");

   a_rise_no_count: assert property (
      s_r.accum_enable && !s_r.accum_mode_select && !s_r.accum_edge_select && rise
      && !cnt_wr |=> s_r.accum_count == $past(s_r.accum_count))
      else $error("count moved on unselected edge");

   a_gate_trail_flag: assert property (
      s_r.accum_enable && s_r.accum_mode_select && !s_r.accum_edge_select && fall
      |=> s_r.accum_input_flag)
      else $error("input flag not set at end of gate");

   a_gate_stopped: assert property (
      !s_r.timer_enable && !$past(s_r.timer_enable) |-> !gate_tick)
      else $error("divided clock runs while timer is off");

   a_count_load: assert property (
      cnt_wr |=> s_r.accum_count == $past(hwdata[ACC_W-1:0]))
      else $error("count write not loaded");

   a_sync_two_ff: assert property (
      $rose(accum_input) |-> $past(port_pin_in[ACC_PIN], 2))
      else $error("accumulator input not two flops behind pin");

   a_pin_data_drive: assert property (
      ((port_pin_out ^ s_r.port_pin_data) & ~$past(oc_pin_use)) == 4'h0)
      else $error("free pin not driven from port data");

   a_pin_dir_oe: assert property (
      ((port_pin_oe ^ s_r.pin_direction) & ~$past(oc_pin_use)) == 4'h0)
      else $error("free pin enable differs from direction");

endmodule // pa_top

/* verif/pa_pin_model.sv */
// Partner model: external circuit on the four timer port pins
module pa_pin_model
   import pa_pkg::*;
(
   // Levels the outside world drives when the device does not
   input  wire logic [PORT_W-1:0] ext_level,
   // Device pin drivers
   input  wire logic [PORT_W-1:0] pin_out,
   input  wire logic [PORT_W-1:0] pin_oe,
   // Resolved wire level seen back by the device
   output logic      [PORT_W-1:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // A driven pin shows the device level; an input pin shows the outside level
   always_comb begin
      for (int i = 0; i < PORT_W; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
      end
   end
endmodule // pa_pin_model

/* verif/tb_top.sv */
// Testbench: register bus, port pins and pulse accumulator checks
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
   $display("BAD %s exp %h got %h", nm, exp, got); end end
module tb_top;
   import pa_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {bit wr; logic [31:0] addr; logic [31:0] data;} pa_row_s;

   logic              hclk = 1'b0;
   logic              hresetn = 1'b0;
   logic              hsel = 1'b0;
   logic [31:0]       haddr = 32'h0000_0000;
   logic [1:0]        htrans = 2'h0;
   logic              hwrite = 1'b0;
   logic [2:0]        hsize = 3'h2;
   logic [31:0]       hwdata = 32'h0000_0000;
   logic              hreadyout, hresp, overflow_irq, input_irq;
   logic [31:0]       hrdata;
   logic [PORT_W-1:0] oc_use = 4'h0, oc_lvl = 4'h0, ext = 4'h0;
   logic [PORT_W-1:0] pin_in, pin_out, pin_oe;
   int                bad_count = 0;
   int                check_count = 0;
   int                cyc = 0;

   localparam logic [31:0] A_FLG = 32'(IDX_FLAG) << 2;
   localparam logic [31:0] A_CNT = 32'(IDX_COUNT) << 2;
   localparam logic [31:0] A_DAT = 32'(IDX_PDATA) << 2;
   localparam logic [31:0] A_DIR = 32'(IDX_PDIR) << 2;
   localparam logic [31:0] A_CTL = 32'(IDX_CTRL) << 2;
   localparam logic [31:0] EN  = 32'h1 << CTL_ENABLE;
   localparam logic [31:0] EDG = 32'h1 << CTL_EDGE;
   localparam logic [31:0] IES = (32'h1 << CTL_IN_IE) | (32'h1 << CTL_OVF_IE);
   localparam logic [31:0] GAT = (32'h1 << CTL_MODE) | EN;

   // 50 MHz clock
   always #10 hclk = ~hclk;

   pa_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .oc_pin_use(oc_use),
      .oc_pin_level(oc_lvl), .port_pin_in(pin_in), .port_pin_out(pin_out),
      .port_pin_oe(pin_oe), .overflow_irq(overflow_irq), .input_irq(input_irq));

   pa_pin_model pins (.ext_level(ext), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

   // Verdict in one place
   task automatic results();
      if (bad_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Hang guard well above the under one thousand cycles the run needs
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         results();
      end
   end

   // One AHB-Lite single transfer; whole words only, upper bits kept clear
   task automatic xfer(input bit wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= wr ? d : 32'h0000_0000;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(1'b1, a, d, x);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
      logic [31:0] x;
      xfer(1'b0, a, 32'h0000_0000, x);
      `CHK(nm, e, x)
      `CHK("hresp", 1'b0, hresp)
   endtask

   // Input pulses held well over two clocks so the synchroniser sees them
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge hclk) ext[ACC_PIN] <= 1'b1;
         repeat (5) @(posedge hclk);
         ext[ACC_PIN] <= 1'b0;
         repeat (5) @(posedge hclk);
      end
   endtask

   pa_row_s rows[] = '{
      '{0, A_FLG, 32'h0}, '{0, A_CNT, 32'h0}, '{0, A_DAT, 32'h0},
      '{0, A_DIR, 32'h0}, '{0, A_CTL, 32'h0},
      '{1, A_DIR, 32'hF}, '{0, A_DIR, 32'hF},
      '{1, A_DAT, 32'hA}, '{0, A_DAT, 32'hA},
      '{1, A_CTL, 32'h83}, '{0, A_CTL, 32'h83}, '{1, A_CTL, 32'h0},
      '{0, 32'h14, 32'h0}, '{1, 32'h14, 32'h5}, '{0, 32'h100, 32'h0},
      '{1, A_CNT, 32'h1234}, '{0, A_DIR, 32'hF}, '{0, A_CNT, 32'h1234}
   };

   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      `CHK("oe_rst", 4'h0, pin_oe)
      // Ordinary register cases
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].addr, rows[i].data);
         else rd(rows[i].addr, rows[i].data, "row");
      end
      // Port drive, output compare ownership
      @(negedge hclk);
      `CHK("pin_out", 4'hA, pin_out)
      `CHK("pin_oe", 4'hF, pin_oe)
      @(posedge hclk);
      oc_use <= 4'h1;
      oc_lvl <= 4'h1;
      wr(A_DAT, 32'h4);
      @(negedge hclk);
      `CHK("oc_out", 4'h5, pin_out)
      rd(A_DAT, 32'h4, "latched");
      oc_use <= 4'h0;
      repeat (2) @(negedge hclk);
      `CHK("oc_free", 4'h4, pin_out)
      wr(A_DIR, 32'h0);
      ext <= 4'h9;
      repeat (3) @(posedge hclk);
      rd(A_DAT, 32'h9, "pin_rd");
      ext <= 4'h0;
      // Event counting, rising edges
      wr(A_CNT, 32'h0);
      wr(A_CTL, EN | EDG | IES);
      pulse(3);
      rd(A_CNT, 32'h3, "ev_cnt");
      rd(A_FLG, 32'h1, "ev_flg");
      `CHK("in_irq", 1'b1, input_irq)
      `CHK("ov_irq0", 1'b0, overflow_irq)
      wr(A_FLG, 32'h0);
      rd(A_FLG, 32'h1, "w0_keep");
      wr(A_FLG, 32'h1);
      rd(A_FLG, 32'h0, "w1_clr");
      `CHK("in_irq0", 1'b0, input_irq)
      // Falling edge select: a rise must not count
      wr(A_CTL, EN | IES);
      @(posedge hclk) ext[ACC_PIN] <= 1'b1;
      repeat (6) @(posedge hclk);
      rd(A_CNT, 32'h3, "fall_r");
      ext[ACC_PIN] <= 1'b0;
      repeat (6) @(posedge hclk);
      rd(A_CNT, 32'h4, "fall_f");
      // Wrap and overflow flag
      wr(A_CNT, 32'hFFFF);
      pulse(1);
      rd(A_CNT, 32'h0, "wrap");
      rd(A_FLG, 32'h3, "ovf");
      `CHK("ov_irq", 1'b1, overflow_irq)
      wr(A_FLG, 32'h1);
      rd(A_FLG, 32'h2, "ovf_keep");
      wr(A_FLG, 32'h2);
      rd(A_FLG, 32'h0, "ovf_clr");
      // Fast clear on a count access
      wr(A_CNT, 32'hFFFF);
      pulse(1);
      wr(A_CTL, EN | IES | (32'h1 << CTL_FAST));
      rd(A_FLG, 32'h3, "fc_pre");
      rd(A_CNT, 32'h0, "fc_cnt");
      rd(A_FLG, 32'h0, "fc_flg");
      // Gated mode: no ticks while the timer is off
      wr(A_CTL, GAT);
      wr(A_CNT, 32'h0);
      ext[ACC_PIN] <= 1'b1;
      repeat (200) @(posedge hclk);
      rd(A_CNT, 32'h0, "gate_off");
      wr(A_CTL, GAT | IES | (32'h1 << CTL_TIMER));
      repeat (200) @(posedge hclk);
      ext[ACC_PIN] <= 1'b0;
      repeat (6) @(posedge hclk);
      rd(A_CNT, 32'h3, "gate_cnt");
      rd(A_FLG, 32'h1, "gate_flg");
      // Gated on low level: rising trailing edge sets the flag
      wr(A_FLG, 32'h1);
      wr(A_CTL, GAT | EDG);
      wr(A_CNT, 32'h0);
      wr(A_CTL, GAT | EDG | (32'h1 << CTL_TIMER));
      repeat (200) @(posedge hclk);
      ext[ACC_PIN] <= 1'b1;
      repeat (6) @(posedge hclk);
      rd(A_CNT, 32'h3, "gate_lo");
      rd(A_FLG, 32'h1, "gate_lo_flg");
      // Reset in mid-run: direction, count and flags go back to zero
      wr(A_DIR, 32'hF);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      `CHK("oe_rst2", 4'h0, pin_oe)
      rd(A_DIR, 32'h0, "dir_rst");
      rd(A_CNT, 32'h0, "cnt_rst");
      rd(A_FLG, 32'h0, "flg_rst");
      results();
   end
endmodule // tb_top
